//--- hw/acs_pkg.sv
// Package for the converter sequencer: register selects, field layout, reset values and machine-cycle counts.
// Assumes a core that presents one register access per clock and a machine-cycle enable from the core timing.
package acs_pkg;
  // Register selects on the special function register port
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  localparam logic [1:0] SEL_RESULT = 2'h1;
  localparam logic [1:0] SEL_REFPROG = 2'h2;
  // Control register layout
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W = 3;
  localparam int CONT_BIT = 3;
  localparam int BUSY_BIT = 4;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'h0f;
  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] REFPROG_RESET = 8'h00;
  // Conversion schedule in machine cycles
  localparam logic [3:0] SAMPLE_CYCLES = 4'h5;
  localparam logic [3:0] CONV_CYCLES = 4'hf;
  localparam logic [3:0] FIRST_SAR_CYCLE = 4'h6;
  // Result width in bits; the first eight of the ten approximation steps resolve one each, the last two change nothing
  localparam int RES_W = 8;
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_APPROX} acs_state_e;
endpackage : acs_pkg

//--- hw/acs_sar.sv
// Successive-approximation register: trial bit walk driven by the sequencer.
// Assumes the comparator output is settled one clock after the trial word changes.
`timescale 1ns/10ps
module acs_sar
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic clear,
  input wire logic step,
  input wire logic cmp_high,
  output logic [7:0] trial
);
  logic [7:0] ptr;
  logic [7:0] code;

  // Pointer walks from MSB down; each step keeps or drops the current bit
  // Trial is registered so each decision judges the word now on the DAC, not the one before
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ptr <= 8'h80;
      code <= 8'h00;
      trial <= 8'h00;
    end
    else if (ce)
    begin
      if (clear)
      begin
        ptr <= 8'h80;
        code <= 8'h00;
        trial <= 8'h80;
      end
      else if (step && ptr != 8'h00)
      begin
        code <= cmp_high ? (code | ptr) : code;
        ptr <= ptr >> 1;
        trial <= (cmp_high ? (code | ptr) : code) | (ptr >> 1);
      end
    end
  end
endmodule : acs_sar

//--- hw/acs_sequencer.sv
// Converter control sequencer: control, result and reference-program registers and the conversion timing.
// Assumes the core asserts mc_tick once per machine cycle and issues register accesses on that cycle.
`timescale 1ns/10ps
module acs_sequencer
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic mc_tick,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_sel,
  input wire logic [7:0] reg_wdata,
  input wire logic cmp_high,
  output logic [7:0] reg_rdata,
  output logic [2:0] channel_sel,
  output logic sample_enable,
  output logic hold_enable,
  output logic [7:0] dac_trial,
  output logic [3:0] internal_upper_reference,
  output logic [3:0] internal_lower_reference,
  output logic conversion_done_irq,
  output logic conversion_in_progress
);
  logic [7:0] converter_control_reg;
  logic [7:0] conversion_result_reg;
  logic [7:0] reference_program_reg;
  acs_pkg::acs_state_e state;
  logic [3:0] mc_count;
  logic start_pending;
  logic sar_clear;
  logic sar_step;
  logic [7:0] trial;
  logic finish;
  logic continuous;
  logic ref_write;
  logic start_req;

  function automatic logic is_write(input logic wr, input logic [1:0] sel, input logic [1:0] target);
    is_write = wr && (sel == target);
  endfunction : is_write

  assign continuous = converter_control_reg[acs_pkg::CONT_BIT];
  // Final machine cycle of the schedule stores the result
  assign finish = mc_tick && (state == acs_pkg::ST_APPROX) && (mc_count == acs_pkg::CONV_CYCLES);
  assign ref_write = is_write(reg_wr, reg_sel, acs_pkg::SEL_REFPROG);
  // A write on a machine-cycle tick starts at once; otherwise it waits for the next tick
  assign start_req = ref_write || start_pending;
  // Continuous restarts need a fresh bit walk too, or they would repeat the old code
  assign sar_clear = mc_tick && (start_req || (finish && continuous));
  assign sar_step = mc_tick && (state == acs_pkg::ST_APPROX) && (mc_count >= acs_pkg::FIRST_SAR_CYCLE);

  acs_sar u_sar
  (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .clear(sar_clear),
    .step(sar_step),
    .cmp_high(cmp_high),
    .trial(trial)
  );

  // Trial word is already a flop inside the approximation register
  assign dac_trial = trial;

  // Reference program register; any write counts as a start, whatever the value
  always_ff @(posedge clk)
  begin
    if (!nrst)
      reference_program_reg <= acs_pkg::REFPROG_RESET;
    else if (ce && is_write(reg_wr, reg_sel, acs_pkg::SEL_REFPROG))
      reference_program_reg <= reg_wdata;
  end

  // Nibbles drive the reference ladders; zero leaves full external span
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      internal_upper_reference <= 4'h0;
      internal_lower_reference <= 4'h0;
    end
    else if (ce)
    begin
      internal_upper_reference <= reference_program_reg[7:4];
      internal_lower_reference <= reference_program_reg[3:0];
    end
  end

  // Control register: channel and mode writable, busy is status only
  always_ff @(posedge clk)
  begin
    if (!nrst)
      converter_control_reg <= acs_pkg::CONTROL_RESET;
    else if (ce && is_write(reg_wr, reg_sel, acs_pkg::SEL_CONTROL))
      converter_control_reg <= reg_wdata & acs_pkg::CONTROL_WRITE_MASK;
  end

  // Start request from a write off a tick held, acted on at the next machine cycle
  always_ff @(posedge clk)
  begin
    if (!nrst)
      start_pending <= 1'b0;
    else if (ce)
    begin
      if (ref_write && !mc_tick)
        start_pending <= 1'b1;
      else if (mc_tick)
        start_pending <= 1'b0;
    end
  end

  // Conversion schedule; a pending start overrides any running conversion
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state <= acs_pkg::ST_IDLE;
      mc_count <= 4'h0;
    end
    else if (ce && mc_tick)
    begin
      if (start_req || (finish && continuous))
      begin
        state <= acs_pkg::ST_SAMPLE;
        mc_count <= 4'h1;
      end
      else
      begin
        case (state)
          acs_pkg::ST_IDLE:
            mc_count <= 4'h0;
          acs_pkg::ST_SAMPLE:
          begin
            mc_count <= mc_count + 4'h1;
            if (mc_count == acs_pkg::SAMPLE_CYCLES)
              state <= acs_pkg::ST_APPROX;
          end
          acs_pkg::ST_APPROX:
          begin
            if (mc_count == acs_pkg::CONV_CYCLES)
            begin
              state <= acs_pkg::ST_IDLE;
              mc_count <= 4'h0;
            end
            else
              mc_count <= mc_count + 4'h1;
          end
          default:
          begin
            state <= acs_pkg::ST_IDLE;
            mc_count <= 4'h0;
          end
        endcase
      end
    end
  end

  // Result register: written by software or by a finished conversion
  always_ff @(posedge clk)
  begin
    if (!nrst)
      conversion_result_reg <= acs_pkg::RESULT_RESET;
    else if (ce)
    begin
      if (finish && !start_req)
        conversion_result_reg <= trial;
      else if (is_write(reg_wr, reg_sel, acs_pkg::SEL_RESULT))
        conversion_result_reg <= reg_wdata;
    end
  end

  // Busy: set on the write itself, cleared at a single conversion's end
  always_ff @(posedge clk)
  begin
    if (!nrst)
      conversion_in_progress <= 1'b0;
    else if (ce)
    begin
      if (is_write(reg_wr, reg_sel, acs_pkg::SEL_REFPROG))
        conversion_in_progress <= 1'b1;
      else if (finish && !continuous && !start_pending)
        conversion_in_progress <= 1'b0;
    end
  end

  // One-clock completion pulse toward the core's interrupt logic
  always_ff @(posedge clk)
  begin
    if (!nrst)
      conversion_done_irq <= 1'b0;
    else if (ce)
      conversion_done_irq <= finish && !start_req;
  end

  // Analog-side controls; sampling switch closed only in the sampling window
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      channel_sel <= 3'h0;
      sample_enable <= 1'b0;
      hold_enable <= 1'b0;
    end
    else if (ce)
    begin
      channel_sel <= converter_control_reg[acs_pkg::CHAN_LSB +: acs_pkg::CHAN_W];
      sample_enable <= (state == acs_pkg::ST_SAMPLE);
      hold_enable <= (state == acs_pkg::ST_APPROX);
    end
  end

  // Read data registered; busy shows live status in its bit
  always_ff @(posedge clk)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (ce && reg_rd)
    begin
      case (reg_sel)
        acs_pkg::SEL_CONTROL:
        begin
          reg_rdata <= converter_control_reg;
          reg_rdata[acs_pkg::BUSY_BIT] <= conversion_in_progress;
        end
        acs_pkg::SEL_RESULT:
          reg_rdata <= conversion_result_reg;
        acs_pkg::SEL_REFPROG:
          reg_rdata <= reference_program_reg;
        default:
          reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule : acs_sequencer

//--- testbench/acs_seq_assertions.sv
// Checker on the sequencer ports: register effects and conversion timing.
// Assumes one machine cycle per clk while a conversion is timed.
`timescale 1ns/10ps
module acs_seq_checker
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_sel,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] channel_sel,
  input wire logic sample_enable,
  input wire logic hold_enable,
  input wire logic [3:0] internal_upper_reference,
  input wire logic [3:0] internal_lower_reference,
  input wire logic conversion_done_irq,
  input wire logic conversion_in_progress
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  wire logic ref_wr = ce && reg_wr && reg_sel == acs_pkg::SEL_REFPROG;
  wire logic ctl_wr = ce && reg_wr && reg_sel == acs_pkg::SEL_CONTROL;
  wire logic ctl_rd = ce && reg_rd && reg_sel == acs_pkg::SEL_CONTROL;
  wire logic [7:0] refs = {internal_upper_reference, internal_lower_reference};
  // Saturates so a long continuous run never wraps into a false match
  logic [7:0] since_wr;
  always_ff @(posedge clk)
  begin
    if (!nrst)
      since_wr <= 8'h00;
    else if (ref_wr)
      since_wr <= 8'h01;
    else if (since_wr != 8'hff)
      since_wr <= since_wr + 8'h01;
  end
  a_busy_on_write: assert property (ref_wr |=> conversion_in_progress)
    else $error("busy not set by start");
  // Nibbles pass through the program register first, so they show two clocks after the write
  a_nibble_split: assert property (ref_wr |-> ##2 (refs == $past(reg_wdata, 2)))
    else $error("reference nibbles wrong");
  a_single_length: assert property ($fell(conversion_in_progress) |-> since_wr == 8'h10)
    else $error("conversion length wrong");
  a_done_pulse: assert property ($fell(conversion_in_progress) |-> conversion_done_irq)
    else $error("no completion request");
  a_sample_five: assert property ($rose(sample_enable) |-> sample_enable [*5] ##1 !sample_enable)
    else $error("sampling length wrong");
  a_approx_after: assert property ($fell(sample_enable) |-> hold_enable)
    else $error("no approximation after sampling");
  a_channel_field: assert property (ctl_wr |-> ##2 (channel_sel == $past(reg_wdata[2:0], 2)))
    else $error("channel field wrong");
  a_busy_readback: assert property (ctl_rd |=> reg_rdata[7:4] == {3'h0, $past(conversion_in_progress)})
    else $error("busy readback wrong");
  c_restart: cover property (ref_wr && conversion_in_progress);
  c_finish: cover property ($fell(conversion_in_progress));
  c_repeat: cover property (conversion_done_irq && conversion_in_progress);
endmodule : acs_seq_checker
bind acs_sequencer acs_seq_checker acs_seq_checker_inst (.clk(clk), .nrst(nrst), .ce(ce), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .channel_sel(channel_sel),
  .sample_enable(sample_enable), .hold_enable(hold_enable), .internal_upper_reference(internal_upper_reference),
  .internal_lower_reference(internal_lower_reference), .conversion_done_irq(conversion_done_irq),
  .conversion_in_progress(conversion_in_progress));

//--- testbench/acs_analog_model.sv
// Analog side model: a fixed level on each channel and the comparator.
// Assumes the trial word is settled before the sequencer samples the comparator.
`timescale 1ns/10ps
module acs_analog_model
(
  input wire logic [2:0] channel_sel,
  input wire logic [7:0] dac_trial,
  output logic cmp_high
);
  // Half an LSB above the code, so the walk lands exactly on it
  assign cmp_high = {channel_sel, 5'h0b, 1'b1} > {dac_trial, 1'b0};
endmodule : acs_analog_model

//--- testbench/tb_top.sv
// Bench for the converter sequencer: register access, timing and modes.
// Assumes one machine cycle per clk, so mc_tick and ce stay high.
`timescale 1ns/10ps
module tb_top;
  logic clk, nrst, reg_wr, reg_rd, cmp_high, sample_enable, hold_enable, conversion_done_irq, conversion_in_progress;
  logic [1:0] reg_sel;
  logic [7:0] reg_wdata, reg_rdata, dac_trial, d;
  logic [2:0] channel_sel;
  logic [3:0] iur, ilr;
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int n;
  acs_sequencer acs_sequencer_inst (.clk(clk), .nrst(nrst), .ce(1'b1), .mc_tick(1'b1), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .cmp_high(cmp_high), .reg_rdata(reg_rdata),
    .channel_sel(channel_sel), .sample_enable(sample_enable), .hold_enable(hold_enable), .dac_trial(dac_trial),
    .internal_upper_reference(iur), .internal_lower_reference(ilr), .conversion_done_irq(conversion_done_irq),
    .conversion_in_progress(conversion_in_progress));
  acs_analog_model acs_analog_model_inst (.channel_sel(channel_sel), .dac_trial(dac_trial), .cmp_high(cmp_high));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      num_errors++;
      results();
    end
  end
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk
  task automatic wr(input logic [1:0] sel, input logic [7:0] v);
    @(posedge clk);
    #1 reg_wr = 1'b1;
    reg_sel = sel;
    reg_wdata = v;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] sel);
    @(posedge clk);
    #1 reg_rd = 1'b1;
    reg_sel = sel;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    @(posedge clk);
    #1 d = reg_rdata;
  endtask : rd
  // Bounded wait so a stuck busy flag cannot hang the run
  task automatic wait_idle;
    n = 0;
    while (conversion_in_progress !== 1'b0 && n < 40)
    begin
      @(posedge clk);
      #1 n++;
    end
  endtask : wait_idle
  task automatic t_rw;
    rd(acs_pkg::SEL_CONTROL);
    chk(d === acs_pkg::CONTROL_RESET, "control reset");
    wr(acs_pkg::SEL_RESULT, 8'ha5);
    rd(acs_pkg::SEL_RESULT);
    chk(d === 8'ha5, "result write");
    wr(2'h3, 8'h5a);
    rd(2'h3);
    chk(d === 8'h00, "unmapped read");
    repeat (20) @(posedge clk);
    rd(acs_pkg::SEL_RESULT);
    chk(d === 8'ha5, "result kept");
    wr(acs_pkg::SEL_CONTROL, 8'hff);
    rd(acs_pkg::SEL_CONTROL);
    chk(d === 8'h0f, "control bits");
  endtask : t_rw
  task automatic t_chan;
    for (int ch = 0; ch < 8; ch++)
    begin
      wr(acs_pkg::SEL_CONTROL, {5'h00, 3'(ch)});
      wr(acs_pkg::SEL_REFPROG, 8'h00);
      chk(conversion_in_progress === 1'b1, "busy on start");
      wait_idle();
      chk(n == 15, "conversion time");
      rd(acs_pkg::SEL_RESULT);
      chk(d === {3'(ch), 5'h0b}, "channel result");
    end
  endtask : t_chan
  task automatic t_restart;
    wr(acs_pkg::SEL_REFPROG, 8'h3c);
    // Nibbles follow the program register one clock later
    @(posedge clk);
    #1 chk(iur === 4'h3 && ilr === 4'hc, "reference nibbles");
    rd(acs_pkg::SEL_CONTROL);
    chk(d === 8'h17, "busy readback");
    repeat (3) @(posedge clk);
    wr(acs_pkg::SEL_CONTROL, 8'h05);
    wr(acs_pkg::SEL_REFPROG, 8'h00);
    wait_idle();
    chk(n == 15, "restart time");
    rd(acs_pkg::SEL_RESULT);
    chk(d === 8'hab, "restart result");
  endtask : t_restart
  task automatic t_cont;
    int k = 0;
    wr(acs_pkg::SEL_CONTROL, 8'h0e);
    wr(acs_pkg::SEL_REFPROG, 8'h00);
    repeat (40)
    begin
      @(posedge clk);
      #1 k += int'(conversion_done_irq === 1'b1);
    end
    chk(k >= 2 && conversion_in_progress === 1'b1, "continuous run");
    wr(acs_pkg::SEL_CONTROL, 8'h06);
    wr(acs_pkg::SEL_REFPROG, 8'h00);
    wait_idle();
    chk(n == 15, "single after continuous");
    rd(acs_pkg::SEL_RESULT);
    chk(d === 8'hcb, "continuous result");
    chk(iur === 4'h0 && ilr === 4'h0, "zero reference");
  endtask : t_cont
  task automatic results;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  initial
  begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_sel = 2'h0;
    reg_wdata = 8'h00;
    repeat (6) @(posedge clk);
    #1 nrst = 1'b1;
    t_rw();
    t_chan();
    t_restart();
    t_cont();
    results();
  end
endmodule : tb_top
